// *** rtl/irq_rise_detect.sv ***
/*
 * rising edge detector for one interrupt level from the keyboard
 * controller. assumes the level is synchronous to clk.
 */
`timescale 1ns/1ps
module irq_rise_detect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level,
    output logic rise
);
    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t st_r;
    edge_state_t st_nxt;

    // remember last level
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = level;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // one-cycle pulse on a low to high step
    assign rise = level & ~st_r.prev;
endmodule : irq_rise_detect

// *** rtl/legacy_kbd_emu.sv ***
/*
 * legacy keyboard and mouse emulation control: control, input, output and
 * status registers on the operational register port, host i/o decode of
 * the two legacy ports, legacy and emulation interrupts.
 * assumes single-cycle register and i/o requests synchronous to clk.
 */
`timescale 1ns/1ps
module legacy_kbd_emu
    import legacy_kbd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mem_sel,
    input wire logic mem_wr,
    input wire logic [11:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    input wire logic io_sel,
    input wire logic io_wr,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_claim,
    input wire logic kbc_kbd_irq,
    input wire logic kbc_mouse_irq,
    output logic keyboard_interrupt,
    output logic mouse_interrupt,
    output logic emulation_irq
);
    typedef struct packed {
        logic emulation_enable;
        logic char_pending;
        logic legacy_irq_enable;
        logic external_irq_enable;
        logic gate_cmd_sequence;
        logic kbd_irq_seen;
        logic mouse_irq_seen;
        logic gate_line_state;
        logic kbd_sup;
        logic mouse_sup;
        logic gate_skip;
        logic emulation_irq_flag;
        logic kbd_int;
        logic mouse_int;
        logic io_claim;
        logic [7:0] in_data;
        logic [7:0] out_data;
        logic [7:0] status;
        logic [7:0] io_rdata;
        logic [31:0] mem_rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic kbd_rise;
    logic mouse_rise;
    logic io_hit;
    logic kbd_cond;
    logic mouse_cond;

    // legacy port match
    function automatic logic is_port(input logic [15:0] a,
                                     input logic [15:0] p);
        is_port = (a == p);
    endfunction : is_port

    // control register image, reserved bits zero
    function automatic logic [31:0] ctl_word(input state_t s);
        ctl_word = {23'h000000, s.gate_line_state, s.mouse_irq_seen,
                    s.kbd_irq_seen, s.gate_cmd_sequence,
                    s.external_irq_enable, s.legacy_irq_enable,
                    s.char_pending, s.emulation_irq_flag,
                    s.emulation_enable};
    endfunction : ctl_word

    irq_rise_detect u_kbd_edge (
        .clk(clk),
        .rst_n(rst_n),
        .level(kbc_kbd_irq),
        .rise(kbd_rise)
    );

    irq_rise_detect u_mouse_edge (
        .clk(clk),
        .rst_n(rst_n),
        .level(kbc_mouse_irq),
        .rise(mouse_rise)
    );

    // next state: register port, edges, i/o decode, interrupts
    always_comb begin
        st_nxt = st_r;
        // legacy ports decoded only while emulation on
        io_hit = io_sel && st_r.emulation_enable &&
                 (is_port(io_addr, IO_DATA_PORT) ||
                  is_port(io_addr, IO_CMD_PORT));
        // release a forced-low legacy line once its cause goes away
        kbd_cond = st_r.emulation_enable && st_r.legacy_irq_enable &&
                   st_r.status[ST_OUT_FULL] && !st_r.status[ST_AUX_FULL];
        mouse_cond = st_r.emulation_enable && st_r.legacy_irq_enable &&
                     st_r.status[ST_OUT_FULL] && st_r.status[ST_AUX_FULL];
        if (!kbd_cond) begin
            st_nxt.kbd_sup = 1'b0;
        end
        if (!mouse_cond) begin
            st_nxt.mouse_sup = 1'b0;
        end
        // register port writes, seen bits write-one-to-clear
        if (mem_sel && mem_wr) begin
            case (mem_addr)
                OFF_CONTROL: begin
                    st_nxt.emulation_enable = mem_wdata[CTL_EMU_EN];
                    st_nxt.char_pending = mem_wdata[CTL_CHAR_PEND];
                    st_nxt.legacy_irq_enable = mem_wdata[CTL_IRQ_EN];
                    st_nxt.external_irq_enable = mem_wdata[CTL_EXT_IRQ_EN];
                    st_nxt.gate_cmd_sequence = mem_wdata[CTL_GATE_SEQ];
                    st_nxt.gate_line_state = mem_wdata[CTL_GATE_STATE];
                    if (mem_wdata[CTL_KBD_SEEN]) begin
                        st_nxt.kbd_irq_seen = 1'b0;
                        st_nxt.kbd_sup = 1'b1;
                    end
                    if (mem_wdata[CTL_MOUSE_SEEN]) begin
                        st_nxt.mouse_irq_seen = 1'b0;
                        st_nxt.mouse_sup = 1'b1;
                    end
                end
                OFF_INPUT: st_nxt.in_data = mem_wdata[7:0];
                OFF_OUTPUT: st_nxt.out_data = mem_wdata[7:0];
                OFF_STATUS: st_nxt.status = mem_wdata[7:0];
                default: ;
            endcase
        end
        // a rising edge wins over a same-cycle clear
        if (kbd_rise) begin
            st_nxt.kbd_irq_seen = 1'b1;
        end
        if (mouse_rise) begin
            st_nxt.mouse_irq_seen = 1'b1;
        end
        // host i/o cycles with their side effects
        st_nxt.io_claim = io_hit;
        if (io_hit && !io_wr) begin
            if (is_port(io_addr, IO_DATA_PORT)) begin
                st_nxt.io_rdata = st_r.out_data;
                st_nxt.status[ST_OUT_FULL] = 1'b0;
            end else begin
                st_nxt.io_rdata = st_r.status;
            end
        end
        if (io_hit && io_wr) begin
            st_nxt.in_data = io_wdata;
            if (is_port(io_addr, IO_DATA_PORT)) begin
                st_nxt.status[ST_IN_FULL] = 1'b1;
                st_nxt.status[ST_CMD_DATA] = 1'b0;
                st_nxt.gate_skip = st_r.gate_cmd_sequence &&
                    (io_wdata[GATE_DATA_BIT] == st_r.gate_line_state);
            end else begin
                st_nxt.status[ST_IN_FULL] = 1'b0;
                st_nxt.status[ST_CMD_DATA] = 1'b1;
                st_nxt.gate_cmd_sequence = (io_wdata == GATE_SEQ_CMD);
                st_nxt.gate_skip = 1'b0;
            end
        end
        // legacy interrupt lines follow output full
        st_nxt.kbd_int = st_nxt.emulation_enable &&
                         st_nxt.legacy_irq_enable &&
                         st_nxt.status[ST_OUT_FULL] &&
                         !st_nxt.status[ST_AUX_FULL] &&
                         !st_nxt.kbd_sup;
        st_nxt.mouse_int = st_nxt.emulation_enable &&
                           st_nxt.legacy_irq_enable &&
                           st_nxt.status[ST_OUT_FULL] &&
                           st_nxt.status[ST_AUX_FULL] &&
                           !st_nxt.mouse_sup;
        // emulation interrupt condition
        st_nxt.emulation_irq_flag =
            (st_nxt.external_irq_enable &&
             (kbc_kbd_irq || kbc_mouse_irq)) ||
            (st_nxt.emulation_enable && st_nxt.char_pending &&
             !st_nxt.status[ST_OUT_FULL]) ||
            (st_nxt.emulation_enable && st_nxt.status[ST_IN_FULL] &&
             !st_nxt.gate_skip);
        // register port read data, one cycle later
        if (mem_sel && !mem_wr) begin
            case (mem_addr)
                OFF_CONTROL: st_nxt.mem_rdata = ctl_word(st_r);
                OFF_INPUT: st_nxt.mem_rdata = {24'h000000, st_r.in_data};
                OFF_OUTPUT: st_nxt.mem_rdata = {24'h000000, st_r.out_data};
                OFF_STATUS: st_nxt.mem_rdata = {24'h000000, st_r.status};
                default: st_nxt.mem_rdata = WORD_RESET;
            endcase
        end
    end

    // state register, all zero after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign mem_rdata = st_r.mem_rdata;
    assign io_rdata = st_r.io_rdata;
    assign io_claim = st_r.io_claim;
    assign keyboard_interrupt = st_r.kbd_int;
    assign mouse_interrupt = st_r.mouse_int;
    assign emulation_irq = st_r.emulation_irq_flag;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic io_wr60;
    logic io_wr64;
    logic io_rd60;
    logic io_rd64;
    assign io_wr60 = io_sel && io_wr && st_r.emulation_enable &&
                     is_port(io_addr, IO_DATA_PORT) && !mem_sel;
    assign io_wr64 = io_sel && io_wr && st_r.emulation_enable &&
                     is_port(io_addr, IO_CMD_PORT) && !mem_sel;
    assign io_rd60 = io_sel && !io_wr && st_r.emulation_enable &&
                     is_port(io_addr, IO_DATA_PORT) && !mem_sel;
    assign io_rd64 = io_sel && !io_wr && st_r.emulation_enable &&
                     is_port(io_addr, IO_CMD_PORT) && !mem_sel;

    AST_GATE_SET: assert property (io_wr64 && io_wdata == GATE_SEQ_CMD
        |=> st_r.gate_cmd_sequence) else $error("gate sequence not set");
    AST_GATE_CLR: assert property (io_wr64 && io_wdata != GATE_SEQ_CMD
        |=> !st_r.gate_cmd_sequence) else $error("gate sequence not cleared");
    AST_CAPTURE: assert property ((io_wr60 || io_wr64)
        |=> st_r.in_data == $past(io_wdata)) else $error("byte not captured");
    AST_WR60: assert property (io_wr60
        |=> st_r.status[ST_IN_FULL] && !st_r.status[ST_CMD_DATA] && io_claim)
        else $error("data port write flags wrong");
    AST_WR64: assert property (io_wr64
        |=> !st_r.status[ST_IN_FULL] && st_r.status[ST_CMD_DATA])
        else $error("command port write flags wrong");
    AST_RD60: assert property (io_rd60
        |=> !st_r.status[ST_OUT_FULL] && io_rdata == $past(st_r.out_data))
        else $error("data port read wrong");
    AST_RD64: assert property (io_rd64
        |=> io_rdata == $past(st_r.status) && $stable(st_r.status))
        else $error("status read had a side effect");
    AST_NO_CLAIM: assert property (io_sel && !st_r.emulation_enable &&
        !mem_sel |=> !io_claim && $stable(st_r.in_data)
        && $stable(st_r.status)) else $error("disabled port claimed");
    AST_KBD_LINE: assert property (keyboard_interrupt
        |-> st_r.status[ST_OUT_FULL] && !st_r.status[ST_AUX_FULL] &&
        st_r.legacy_irq_enable && st_r.emulation_enable)
        else $error("keyboard line without cause");
    AST_MOUSE_LINE: assert property (mouse_interrupt
        |-> st_r.status[ST_OUT_FULL] && st_r.status[ST_AUX_FULL])
        else $error("mouse line without cause");
    AST_KBD_SEEN: assert property (kbd_rise
        |=> st_r.kbd_irq_seen) else $error("keyboard edge missed");
    AST_MOUSE_W1C: assert property (mem_sel && mem_wr &&
        mem_addr == OFF_CONTROL && mem_wdata[CTL_MOUSE_SEEN] && !mouse_rise
        |=> !st_r.mouse_irq_seen && !mouse_interrupt)
        else $error("mouse write-one did not clear");
    AST_CHAR_PEND: assert property (st_r.emulation_enable &&
        st_r.char_pending && !st_r.status[ST_OUT_FULL] |-> emulation_irq)
        else $error("character pending interrupt missing");
    AST_EXT_IRQ: assert property (!mem_sel && st_r.external_irq_enable &&
        kbc_kbd_irq |=> emulation_irq)
        else $error("external interrupt not routed");
    AST_MEM_QUIET: assert property (mem_sel && mem_addr == OFF_INPUT &&
        !io_sel |=> $stable(st_r.status))
        else $error("input register access changed status");

    COV_GATE: cover property (io_wr64 && io_wdata == GATE_SEQ_CMD
        ##[1:20] io_wr60);
    COV_RD60: cover property (st_r.status[ST_OUT_FULL] && io_rd60);
    COV_MOUSE: cover property (mouse_interrupt ##[1:20] !mouse_interrupt);
endmodule : legacy_kbd_emu

// *** rtl/legacy_kbd_pkg.sv ***
/*
 * constants for the legacy keyboard and mouse emulation control block:
 * operational register offsets, bit positions, port numbers, reset values.
 * assumes a 32-bit operational register window and 16-bit host i/o ports.
 */
package legacy_kbd_pkg;
    // operational register offsets
    localparam logic [11:0] OFF_CONTROL = 12'h100;
    localparam logic [11:0] OFF_INPUT = 12'h104;
    localparam logic [11:0] OFF_OUTPUT = 12'h108;
    localparam logic [11:0] OFF_STATUS = 12'h10C;
    // legacy host i/o ports
    localparam logic [15:0] IO_DATA_PORT = 16'h0060;
    localparam logic [15:0] IO_CMD_PORT = 16'h0064;
    // gate sequence command byte and compared data bit
    localparam logic [7:0] GATE_SEQ_CMD = 8'hD1;
    localparam int GATE_DATA_BIT = 1;
    // control register bit positions
    localparam int CTL_EMU_EN = 0;
    localparam int CTL_EMU_IRQ = 1;
    localparam int CTL_CHAR_PEND = 2;
    localparam int CTL_IRQ_EN = 3;
    localparam int CTL_EXT_IRQ_EN = 4;
    localparam int CTL_GATE_SEQ = 5;
    localparam int CTL_KBD_SEEN = 6;
    localparam int CTL_MOUSE_SEEN = 7;
    localparam int CTL_GATE_STATE = 8;
    // status register bit positions
    localparam int ST_OUT_FULL = 0;
    localparam int ST_IN_FULL = 1;
    localparam int ST_CMD_DATA = 3;
    localparam int ST_AUX_FULL = 5;
    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
endpackage : legacy_kbd_pkg

// *** verif/legacy_io_host.sv ***
/*
 * host model that issues legacy keyboard port cycles one at a time.
 * assumes the block samples a request on the rising edge of clk and
 * answers with registered data one cycle later.
 */
`timescale 1ns/1ps
module legacy_io_host (
    input wire logic clk,
    output logic io_sel,
    output logic io_wr,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_claim
);
    // bus idle at time zero
    initial begin
        io_sel = 1'b0;
        io_wr = 1'b0;
        io_addr = 16'h0000;
        io_wdata = 8'h00;
    end

    // one in or out cycle; released lines are scrambled, never left stale
    task automatic io_cycle(input logic wr, input logic [15:0] addr,
                            input logic [7:0] wdata, output logic [7:0] rd,
                            output logic claim);
        @(posedge clk);
        #1;
        io_sel = 1'b1;
        io_wr = wr;
        io_addr = addr;
        io_wdata = wdata;
        @(posedge clk);
        #1;
        io_sel = 1'b0;
        io_wr = ~io_wr;
        io_addr = ~io_addr;
        io_wdata = ~io_wdata;
        rd = io_rdata;
        claim = io_claim;
    endtask : io_cycle
endmodule : legacy_io_host

// *** verif/test_legacy_kbd_emu.sv ***
/*
 * self-checking bench for the legacy keyboard emulation block: a table
 * of register and port accesses, then interrupt, gate and reset cases.
 * assumes the host model drives the port side and the bench the rest.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    bad_count++; $display("mismatch %0t got %h exp %h", $time, got, exp); \
    end end
module test_legacy_kbd_emu;
    import legacy_kbd_pkg::*;
    typedef struct {int op; logic [15:0] addr; logic [31:0] data;
        logic [31:0] exp;} row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mem_sel = 1'b0;
    logic mem_wr = 1'b0;
    logic [11:0] mem_addr = 12'h000;
    logic [31:0] mem_wdata = 32'h00000000;
    logic [31:0] mem_rdata;
    logic io_sel, io_wr, io_claim;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, rd8;
    logic kbc_kbd_irq = 1'b0;
    logic kbc_mouse_irq = 1'b0;
    logic keyboard_interrupt, mouse_interrupt, emulation_irq, claim;
    logic [31:0] rd32, seen;
    int bad_count = 0;
    int checked = 0;
    // op 0 reg write, 1 reg read, 2 port out (exp claim), 3 port in
    row_t rows [0:24] = '{
        '{1, 16'h0104, 0, 0}, '{1, 16'h0100, 0, 0},
        '{2, 16'h0060, 32'h55, 0}, '{1, 16'h0104, 0, 0},
        '{0, 16'h0100, 32'hFFFFFE01, 0}, '{1, 16'h0100, 0, 32'h01},
        '{2, 16'h0060, 32'hA5, 1}, '{1, 16'h0104, 0, 32'hA5},
        '{1, 16'h010C, 0, 32'h02}, '{2, 16'h0064, 32'hD1, 1},
        '{1, 16'h010C, 0, 32'h08}, '{1, 16'h0100, 0, 32'h21},
        '{0, 16'h0104, 32'hFFFFFF3C, 0}, '{1, 16'h0104, 0, 32'h3C},
        '{1, 16'h010C, 0, 32'h08}, '{2, 16'h0070, 32'h11, 0},
        '{0, 16'h0108, 32'hFFFFFF5A, 0}, '{0, 16'h010C, 32'h01, 0},
        '{3, 16'h0064, 0, 32'h01}, '{1, 16'h010C, 0, 32'h01},
        '{3, 16'h0060, 0, 32'h5A}, '{1, 16'h010C, 0, 32'h00},
        '{2, 16'h0064, 32'h00, 1}, '{1, 16'h0100, 0, 32'h01},
        '{1, 16'h0200, 0, 0}};

    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    legacy_kbd_emu u_dut (.clk(clk), .rst_n(rst_n), .mem_sel(mem_sel),
        .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .io_sel(io_sel), .io_wr(io_wr),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_claim(io_claim), .kbc_kbd_irq(kbc_kbd_irq),
        .kbc_mouse_irq(kbc_mouse_irq),
        .keyboard_interrupt(keyboard_interrupt),
        .mouse_interrupt(mouse_interrupt), .emulation_irq(emulation_irq));

    legacy_io_host u_host (.clk(clk), .io_sel(io_sel), .io_wr(io_wr),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_claim(io_claim));

    // let edges pass, then settle just after the last one
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cycles

    // one register access, request held across the sampling edge
    task automatic mem_acc(input logic wr, input logic [15:0] addr,
                           input logic [31:0] wd, output logic [31:0] rd);
        wait_cycles(1);
        mem_sel = 1'b1;
        mem_wr = wr;
        mem_addr = addr[11:0];
        mem_wdata = wd;
        wait_cycles(1);
        mem_sel = 1'b0;
        rd = mem_rdata;
    endtask : mem_acc

    task automatic wr(input logic [15:0] addr, input logic [31:0] wd);
        logic [31:0] dummy;
        mem_acc(1'b1, addr, wd, dummy);
    endtask : wr

    task automatic rd_chk(input logic [15:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        mem_acc(1'b0, addr, 32'h00000000, got);
        `CHK(got, exp)
    endtask : rd_chk

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    // main sequence: table first, then hand-written cases
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        foreach (rows[i]) begin
            if (rows[i].op < 2) begin
                mem_acc(rows[i].op == 0, rows[i].addr, rows[i].data, rd32);
                if (rows[i].op == 1) `CHK(rd32, rows[i].exp)
            end else begin
                u_host.io_cycle(rows[i].op == 2, rows[i].addr,
                                rows[i].data[7:0], rd8, claim);
                `CHK(claim, rows[i].op == 3 ? 1'b1 : rows[i].exp[0])
                if (rows[i].op == 3) `CHK(rd8, rows[i].exp[7:0])
            end
        end
        // legacy line choice, seen bits and write-one drop
        for (int aux = 0; aux < 2; aux++) begin
            wr(16'h010C, aux ? 32'h21 : 32'h01);
            wr(16'h0100, 32'h09);
            wait_cycles(2);
            `CHK(keyboard_interrupt, aux == 0)
            `CHK(mouse_interrupt, aux == 1)
            kbc_kbd_irq = (aux == 0);
            kbc_mouse_irq = (aux == 1);
            wait_cycles(2);
            seen = aux ? 32'h89 : 32'h49;
            wr(16'h0100, 32'h09);
            rd_chk(16'h0100, seen);
            wr(16'h0100, seen);
            wait_cycles(2);
            `CHK({keyboard_interrupt, mouse_interrupt}, 2'b00)
            rd_chk(16'h0100, 32'h09);
            kbc_kbd_irq = 1'b0;
            kbc_mouse_irq = 1'b0;
        end
        // emulation off keeps the keyboard line quiet
        wr(16'h010C, 32'h01);
        wr(16'h0100, 32'h08);
        wait_cycles(2);
        `CHK(keyboard_interrupt, 1'b0)
        // external interrupts with emulation off
        wr(16'h0100, 32'h10);
        kbc_kbd_irq = 1'b1;
        wait_cycles(2);
        `CHK(emulation_irq, 1'b1)
        rd_chk(16'h0100, 32'h52);
        kbc_kbd_irq = 1'b0;
        kbc_mouse_irq = 1'b1;
        wait_cycles(2);
        `CHK(emulation_irq, 1'b1)
        kbc_mouse_irq = 1'b0;
        wait_cycles(2);
        `CHK(emulation_irq, 1'b0)
        // character pending follows output full
        wr(16'h010C, 32'h00);
        wr(16'h0100, 32'h05);
        wait_cycles(2);
        `CHK(emulation_irq, 1'b1)
        wr(16'h010C, 32'h01);
        wait_cycles(2);
        `CHK(emulation_irq, 1'b0)
        // output data kept its byte, upper bits written as ones read zero
        rd_chk(16'h0108, 32'h5A);
        // gate sequence: matching byte is absorbed, other byte interrupts
        wr(16'h0100, 32'h101);
        for (int k = 0; k < 2; k++) begin
            u_host.io_cycle(1'b1, IO_CMD_PORT, GATE_SEQ_CMD, rd8, claim);
            u_host.io_cycle(1'b1, IO_DATA_PORT, k ? 8'h04 : 8'h02, rd8, claim);
            wait_cycles(2);
            `CHK(emulation_irq, k == 1)
        end
        // reset in mid-run
        rst_n = 1'b0;
        wait_cycles(2);
        rst_n = 1'b1;
        rd_chk(16'h0100, 32'h00);
        rd_chk(16'h0104, 32'h00);
        rd_chk(16'h010C, 32'h00);
        print_verdict();
    end
endmodule : test_legacy_kbd_emu
